// >>> hdl/zcpo_top.sv
// Behaviour
// - With request asserted, clamp engages once speed reference falls below clamp level.
// - Deasserting the request leaves clamp; speed reference is followed again.
// - Dedicated request pin works only in reassign mode with an allocated input.
// - Clamp only for method codes 0, 3, 4, 5, 6, 7, 9, A.
// - Codes 5, 6, 7, 9: clamp off unless speed or internal speed active.
// - Clamp allocation 7: clamp in speed control whenever below level, no request.
// - Clamp level 0 to 10000 rpm, default 10, effective immediately.
// - Clamp level above motor maximum speed is limited to maximum speed.
// - Encoder position becomes quadrature pair A and B, 90 degrees apart.
// - Quadrature outputs give exactly the set pulses per revolution up to ENC_CPR/4; higher settings give ENC_CPR/4 in forward rotation and stall in reverse.
// - Origin output gives one pulse per motor revolution up to ENC_CPR/4 set pulses, else one per 4 x set pulses counts in forward rotation only.
// - Origin pulse width equals one phase A pulse.
// - Reverse rotation select leaves the output phase form unchanged.
// - During clamp, speed reference ignored; position loop holds engage position.
// - Held within one count; displacement drives the motor back.
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module zcpo_top #(
    parameter int ENC_CPR = 131072
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        clamp_request_input,
    input  wire logic        proportional_control_input,
    input  wire logic        method_switch_input,
    input  wire logic [15:0] speed_reference,
    input  wire logic [31:0] encoder_position,
    input  wire logic        encoder_step,
    input  wire logic        encoder_dir_up,
    output logic      [15:0] speed_command,
    output logic             clamp_active,
    output logic             feedback_phase_a,
    output logic             feedback_phase_b,
    output logic             feedback_origin_pulse
);
    import zcpo_pkg::*;

    // ************************************************************
    // Reset release
    // ************************************************************
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [2:0] pins_lvl;
    logic       req_pin, pcon_pin, sel_pin;

    zcpo_pin_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk       (core_clk),
        .rst_n     (rst_n),
        .pin_in    ({method_switch_input, proportional_control_input, clamp_request_input}),
        .level_out (pins_lvl)
    );

    assign req_pin  = pins_lvl[0];
    assign pcon_pin = pins_lvl[1];
    assign sel_pin  = pins_lvl[2];

    // ************************************************************
    // Configuration registers and Avalon slave
    // ************************************************************
    logic [3:0]  method_q, method_d;
    logic        dir_q, dir_d;
    logic        amode_q, amode_d;
    logic [3:0]  calloc_q, calloc_d;
    logic [13:0] level_q, level_d;
    logic [13:0] maxspd_q, maxspd_d;
    logic [30:0] ppr_q, ppr_d;
    logic [3:0]  gain_q, gain_d;
    logic        ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic        access;
    logic [31:0] status_w;

    logic        clamp_q, clamp_d;
    logic [31:0] hold_q, hold_d;
    logic [15:0] cmd_q, cmd_d;
    logic        meth_ok, spd_act, req_eff;

    assign access          = avs_read || avs_write;
    assign avs_waitrequest = access && !ack_q;

    always_comb begin
        status_w                  = '0;
        status_w[STAT_CLAMP_BIT]  = clamp_q;
        status_w[STAT_METHOD_BIT] = meth_ok;
        status_w[STAT_SPEED_BIT]  = spd_act;
        status_w[STAT_REQ_BIT]    = req_eff;
    end

    always_comb begin
        method_d = method_q;
        dir_d    = dir_q;
        amode_d  = amode_q;
        calloc_d = calloc_q;
        level_d  = level_q;
        maxspd_d = maxspd_q;
        ppr_d    = ppr_q;
        gain_d   = gain_q;
        ack_d    = access && !ack_q;
        rdata_d  = rdata_q;
        if (avs_write && ack_q) begin
            case (avs_address)
                OFS_CTRL: begin
                    method_d = avs_writedata[CTRL_METHOD_LSB +: 4];
                    dir_d    = avs_writedata[CTRL_DIR_BIT];
                    amode_d  = avs_writedata[CTRL_AMODE_BIT];
                    calloc_d = avs_writedata[CTRL_CALLOC_LSB +: 4];
                end
                OFS_LEVEL: begin
                    if (avs_writedata > 32'(LEVEL_MAX)) begin
                        level_d = LEVEL_MAX;
                    end else begin
                        level_d = avs_writedata[13:0];
                    end
                end
                OFS_MAXSPD: begin
                    maxspd_d = avs_writedata[13:0];
                end
                OFS_PPR: begin
                    if (avs_writedata < 32'(PPR_MIN)) begin
                        ppr_d = PPR_MIN;
                    end else if (avs_writedata > 32'(PPR_MAX)) begin
                        ppr_d = PPR_MAX;
                    end else begin
                        ppr_d = avs_writedata[30:0];
                    end
                end
                OFS_GAIN: begin
                    gain_d = avs_writedata[3:0];
                end
                default: begin
                end
            endcase
        end
        if (avs_read && !ack_q) begin
            case (avs_address)
                OFS_CTRL:   rdata_d = 32'(method_q) | (32'(dir_q) << CTRL_DIR_BIT)
                                      | (32'(amode_q) << CTRL_AMODE_BIT)
                                      | (32'(calloc_q) << CTRL_CALLOC_LSB);
                OFS_LEVEL:  rdata_d = 32'(level_q);
                OFS_MAXSPD: rdata_d = 32'(maxspd_q);
                OFS_PPR:    rdata_d = 32'(ppr_q);
                OFS_GAIN:   rdata_d = 32'(gain_q);
                OFS_STATUS: rdata_d = status_w;
                OFS_HOLD:   rdata_d = hold_q;
                OFS_SPDCMD: rdata_d = {{16{cmd_q[15]}}, cmd_q};
                default:    rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            method_q <= METHOD_RST;
            dir_q    <= 1'b0;
            amode_q  <= 1'b0;
            calloc_q <= CALLOC_RST;
            level_q  <= LEVEL_RST;
            maxspd_q <= MAXSPD_RST;
            ppr_q    <= PPR_RST;
            gain_q   <= GAIN_RST;
            ack_q    <= 1'b0;
            rdata_q  <= 32'h00000000;
        end else begin
            method_q <= method_d;
            dir_q    <= dir_d;
            amode_q  <= amode_d;
            calloc_q <= calloc_d;
            level_q  <= level_d;
            maxspd_q <= maxspd_d;
            ppr_q    <= ppr_d;
            gain_q   <= gain_d;
            ack_q    <= ack_d;
            rdata_q  <= rdata_d;
        end
    end

    assign avs_readdata = rdata_q;

    // ************************************************************
    // Zero clamp decision and position hold loop
    // ************************************************************
    logic [13:0]        eff_level;
    logic [16:0]        ref_mag;
    logic               below;
    logic signed [31:0] pos_err;
    logic signed [47:0] loop_out;

    function automatic logic [15:0] sat16(input logic signed [47:0] v);
        if (v > 48'sh007FFF) begin
            sat16 = 16'h7FFF;
        end else if (v < -48'sh008000) begin
            sat16 = 16'h8000;
        end else begin
            sat16 = v[15:0];
        end
    endfunction

    always_comb begin
        eff_level = (level_q > maxspd_q) ? maxspd_q : level_q;
        ref_mag   = speed_reference[15] ? 17'(-$signed({1'b1, speed_reference}))
                                        : {1'b0, speed_reference};
        below     = ref_mag < {3'h0, eff_level};
        meth_ok   = zcpo_method_ok(method_q);
        spd_act   = zcpo_speed_active(method_q, sel_pin);
        if (amode_q) begin
            if (calloc_q == CALLOC_ALWAYS) begin
                req_eff = 1'b1;
            end else if (calloc_q < CALLOC_ALWAYS) begin
                req_eff = req_pin;
            end else begin
                req_eff = 1'b0;
            end
        end else begin
            req_eff = (method_q == M_SPD_ZCL) && pcon_pin;
        end
        clamp_d  = req_eff && meth_ok && spd_act && (clamp_q || below);
        hold_d   = (clamp_d && !clamp_q) ? encoder_position : hold_q;
        pos_err  = $signed(hold_q - encoder_position);
        loop_out = 48'(pos_err) <<< gain_q;
        cmd_d    = clamp_q ? sat16(loop_out) : speed_reference;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clamp_q <= 1'b0;
            hold_q  <= 32'h00000000;
            cmd_q   <= 16'h0000;
        end else begin
            clamp_q <= clamp_d;
            hold_q  <= hold_d;
            cmd_q   <= cmd_d;
        end
    end

    assign speed_command = cmd_q;
    assign clamp_active  = clamp_q;

    // ************************************************************
    // Encoder pulse output
    // ************************************************************
    zcpo_pls_if pls ();

    assign pls.ppr    = ppr_q;
    assign pls.step   = encoder_step;
    assign pls.dir_up = encoder_dir_up;

    zcpo_pulse_gen #(
        .ENC_CPR (ENC_CPR)
    ) u_pulse (
        .clk   (core_clk),
        .rst_n (rst_n),
        .pls   (pls)
    );

    assign feedback_phase_a      = pls.phase_a;
    assign feedback_phase_b      = pls.phase_b;
    assign feedback_origin_pulse = pls.origin;
endmodule
`default_nettype wire

// >>> hdl/zcpo_pkg.sv
package zcpo_pkg;

    // ************************************************************
    // Register map (byte offsets)
    // ************************************************************
    localparam logic [4:0] OFS_CTRL     = 5'h00;
    localparam logic [4:0] OFS_LEVEL    = 5'h04;
    localparam logic [4:0] OFS_MAXSPD   = 5'h08;
    localparam logic [4:0] OFS_PPR      = 5'h0C;
    localparam logic [4:0] OFS_GAIN     = 5'h10;
    localparam logic [4:0] OFS_STATUS   = 5'h14;
    localparam logic [4:0] OFS_HOLD     = 5'h18;
    localparam logic [4:0] OFS_SPDCMD   = 5'h1C;

    // ************************************************************
    // Control word fields
    // ************************************************************
    localparam int CTRL_METHOD_LSB = 0;
    localparam int CTRL_DIR_BIT    = 4;
    localparam int CTRL_AMODE_BIT  = 8;
    localparam int CTRL_CALLOC_LSB = 12;

    // ************************************************************
    // Status word fields
    // ************************************************************
    localparam int STAT_CLAMP_BIT  = 0;
    localparam int STAT_METHOD_BIT = 1;
    localparam int STAT_SPEED_BIT  = 2;
    localparam int STAT_REQ_BIT    = 3;

    // ************************************************************
    // Reset values and limits
    // ************************************************************
    localparam logic [3:0]  METHOD_RST  = 4'h0;
    localparam logic [3:0]  CALLOC_RST  = 4'h8;
    localparam logic [13:0] LEVEL_RST   = 14'h000A;
    localparam logic [13:0] LEVEL_MAX   = 14'h2710;
    localparam logic [13:0] MAXSPD_RST  = 14'h1770;
    localparam logic [30:0] PPR_RST     = 31'h00000800;
    localparam logic [30:0] PPR_MIN     = 31'h00000010;
    localparam logic [30:0] PPR_MAX     = 31'h40000000;
    localparam logic [3:0]  GAIN_RST    = 4'h4;

    // ************************************************************
    // Codes
    // ************************************************************
    localparam logic [3:0] CALLOC_ALWAYS = 4'h7;
    localparam logic [3:0] CALLOC_NONE   = 4'h8;
    localparam logic [3:0] M_SPEED       = 4'h0;
    localparam logic [3:0] M_INT         = 4'h3;
    localparam logic [3:0] M_INT_SPD     = 4'h4;
    localparam logic [3:0] M_INT_POS     = 4'h5;
    localparam logic [3:0] M_INT_TRQ     = 4'h6;
    localparam logic [3:0] M_POS_SPD     = 4'h7;
    localparam logic [3:0] M_TRQ_SPD     = 4'h9;
    localparam logic [3:0] M_SPD_ZCL     = 4'hA;

    // Method codes that support the clamp
    function automatic logic zcpo_method_ok(input logic [3:0] code);
        case (code)
            M_SPEED, M_INT, M_INT_SPD, M_INT_POS, M_INT_TRQ,
            M_POS_SPD, M_TRQ_SPD, M_SPD_ZCL: zcpo_method_ok = 1'b1;
            default:                         zcpo_method_ok = 1'b0;
        endcase
    endfunction

    // Active method is speed or internal set speed; sel picks the second method
    function automatic logic zcpo_speed_active(input logic [3:0] code, input logic sel);
        case (code)
            M_INT_POS, M_INT_TRQ: zcpo_speed_active = ~sel;
            M_POS_SPD, M_TRQ_SPD: zcpo_speed_active = sel;
            default:              zcpo_speed_active = zcpo_method_ok(code);
        endcase
    endfunction

endpackage

// >>> hdl/zcpo_pls_if.sv
`timescale 1ns/1ps
`default_nettype none
interface zcpo_pls_if;
    logic [30:0] ppr;
    logic        step;
    logic        dir_up;
    logic        phase_a;
    logic        phase_b;
    logic        origin;

    modport gen (input ppr, input step, input dir_up,
                 output phase_a, output phase_b, output origin);
    modport src (output ppr, output step, output dir_up,
                 input phase_a, input phase_b, input origin);
endinterface
`default_nettype wire

// >>> hdl/zcpo_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module zcpo_pin_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

    // ************************************************************
    // Accept a change once second and third stages agree
    // ************************************************************
    always_comb begin
        lvl_d = lvl_q;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                lvl_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
        end else begin
            s1_q  <= pin_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level_out = lvl_q;
endmodule
`default_nettype wire

// >>> hdl/zcpo_pulse_gen.sv
`timescale 1ns/1ps
`default_nettype none
module zcpo_pulse_gen #(
    parameter int ENC_CPR = 131072
) (
    input  wire logic clk,
    input  wire logic rst_n,
    zcpo_pls_if.gen   pls
);
    localparam logic [33:0] CPR = 34'(ENC_CPR);

    logic [33:0] acc_q, acc_d, q_q, q_d, quads, q_base;
    logic        a_q, a_d, b_q, b_d, o_q, o_d;

    // ************************************************************
    // Encoder count divider and quadrature sequencer
    // ************************************************************
    always_comb begin
        quads  = {1'b0, pls.ppr, 2'b00};
        q_base = (q_q >= quads) ? '0 : q_q;
        acc_d  = acc_q;
        q_d    = q_base;
        if (pls.step) begin
            if (pls.dir_up) begin
                if (acc_q + quads >= CPR) begin
                    acc_d = acc_q + quads - CPR;
                    q_d   = (q_base == quads - 34'h1) ? '0 : q_base + 34'h1;
                end else begin
                    acc_d = acc_q + quads;
                end
            end else begin
                if (acc_q < quads) begin
                    acc_d = acc_q + CPR - quads;
                    q_d   = (q_base == '0) ? quads - 34'h1 : q_base - 34'h1;
                end else begin
                    acc_d = acc_q - quads;
                end
            end
        end
        a_d = (q_d[1:0] == 2'h0) || (q_d[1:0] == 2'h1);
        b_d = (q_d[1:0] == 2'h1) || (q_d[1:0] == 2'h2);
        o_d = (q_d[33:2] == '0) && a_d;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= '0;
            q_q   <= '0;
            a_q   <= 1'b0;
            b_q   <= 1'b0;
            o_q   <= 1'b0;
        end else begin
            acc_q <= acc_d;
            q_q   <= q_d;
            a_q   <= a_d;
            b_q   <= b_d;
            o_q   <= o_d;
        end
    end

    assign pls.phase_a = a_q;
    assign pls.phase_b = b_q;
    assign pls.origin  = o_q;
endmodule
`default_nettype wire

// >>> verification/zcpo_host_dec.sv
`timescale 1ns/1ps
`default_nettype none
module zcpo_host_dec (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pha,
    input  wire logic phb,
    input  wire logic org,
    output int        pos,
    output int        a_rises,
    output int        org_rises
);
    // ********
    // Quadrature decoder
    // ********
    logic [1:0] st_q;
    logic [1:0] st_now;
    logic       pa_q;
    logic       po_q;

    // States 0..3 follow A leading B
    assign st_now = {~pha, ~(pha ^ phb)};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q      <= 2'h3;
            pa_q      <= 1'b0;
            po_q      <= 1'b0;
            pos       <= 0;
            a_rises   <= 0;
            org_rises <= 0;
        end else begin
            st_q <= st_now;
            pa_q <= pha;
            po_q <= org;
            if (st_now == st_q + 2'h1) begin
                pos <= pos + 1;
            end else if (st_now == st_q - 2'h1) begin
                pos <= pos - 1;
            end
            if (pha && !pa_q) begin
                a_rises <= a_rises + 1;
            end
            if (org && !po_q) begin
                org_rises <= org_rises + 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/zcpo_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module zcpo_top_chk (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        encoder_step,
    input  wire logic        encoder_dir_up,
    input  wire logic [31:0] encoder_position,
    input  wire logic [15:0] speed_reference,
    input  wire logic [15:0] speed_command,
    input  wire logic        clamp_active,
    input  wire logic        feedback_phase_a,
    input  wire logic        feedback_phase_b,
    input  wire logic        feedback_origin_pulse
);
    // ********
    // Settle counter after reset
    // ********
    logic [2:0] up_q;
    logic       ok;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            up_q <= 3'h0;
        end else if (up_q != 3'h7) begin
            up_q <= up_q + 3'h1;
        end
    end
    assign ok = (up_q == 3'h7);

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // ********
    // Checks
    // ********
    a_quad_gray: assert property (ok |-> !($changed(feedback_phase_a) && $changed(feedback_phase_b)))
        else $error("A and B changed together");
    a_quad_cause: assert property (ok && ($changed(feedback_phase_a) || $changed(feedback_phase_b))
        |-> $past(encoder_step))
        else $error("Phase change without encoder step");
    a_a_dir: assert property (ok && $changed(feedback_phase_a)
        |-> ((feedback_phase_a != feedback_phase_b) == $past(encoder_dir_up)))
        else $error("Phase A edge against direction");
    a_b_dir: assert property (ok && $changed(feedback_phase_b)
        |-> ((feedback_phase_a == feedback_phase_b) == $past(encoder_dir_up)))
        else $error("Phase B edge against direction");
    a_origin_in_a: assert property (feedback_origin_pulse |-> feedback_phase_a)
        else $error("Origin high outside phase A");
    a_origin_rise: assert property (ok && $rose(feedback_origin_pulse) |-> $rose(feedback_phase_a))
        else $error("Origin rise not with phase A rise");
    a_cmd_follow: assert property (ok && !clamp_active && !$past(clamp_active)
        |-> speed_command == $past(speed_reference))
        else $error("Command does not follow reference");
    a_cmd_hold: assert property (ok && clamp_active && $past(clamp_active) && $past(clamp_active, 2)
        && $past(clamp_active, 3) && $past(encoder_position) == $past(encoder_position, 2)
        |-> $stable(speed_command))
        else $error("Clamp command moved without motion");
endmodule
`default_nettype wire

// >>> verification/zcpo_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module zcpo_top_tb;
    import zcpo_pkg::*;
    // ********
    // Signals
    // ********
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        req = 1'b0;
    logic        prop = 1'b0;
    logic        sw = 1'b0;
    logic        step = 1'b0;
    logic        up = 1'b1;
    logic [15:0] spd_ref = 16'h0000;
    logic [31:0] enc_pos = 32'h000003E8;
    logic [15:0] cmd;
    logic        clamp;
    logic        fa;
    logic        fb;
    logic        fo;
    int          pos;
    int          a_rises;
    int          org_rises;
    int          err_total = 0;
    int          compares = 0;
    int          cycles = 0;
    int          p0;
    int          a0;
    int          o0;

    always #12.5 core_clk = ~core_clk;

    zcpo_top #(.ENC_CPR(128)) i_dut (
        .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .clamp_request_input(req), .proportional_control_input(prop),
        .method_switch_input(sw), .speed_reference(spd_ref), .encoder_position(enc_pos),
        .encoder_step(step), .encoder_dir_up(up), .speed_command(cmd), .clamp_active(clamp),
        .feedback_phase_a(fa), .feedback_phase_b(fb), .feedback_origin_pulse(fo)
    );

    zcpo_host_dec i_host (
        .clk(core_clk), .rst_n(reset_n), .pha(fa), .phb(fb), .org(fo),
        .pos(pos), .a_rises(a_rises), .org_rises(org_rises)
    );

    // ********
    // Tasks
    // ********
    task close_out;
        $display("Counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            close_out;
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= ~w;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        @(posedge core_clk);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    task cl(input logic exp);
        repeat (12) @(posedge core_clk);
        chk({31'h0, clamp}, {31'h0, exp});
    endtask

    task steps(input int n, input logic dir);
        repeat (n) begin
            @(posedge core_clk);
            step    <= 1'b1;
            up      <= dir;
            enc_pos <= dir ? enc_pos + 32'h1 : enc_pos - 32'h1;
            @(posedge core_clk);
            step <= 1'b0;
        end
        repeat (3) @(posedge core_clk);
    endtask

    task snap;
        p0 = pos;
        a0 = a_rises;
        o0 = org_rises;
    endtask

    function automatic logic exp_cl(input int c, input int s);
        case (c)
            0, 3, 4, 10: exp_cl = 1'b1;
            5, 6:        exp_cl = (s == 0);
            7, 9:        exp_cl = (s == 1);
            default:     exp_cl = 1'b0;
        endcase
    endfunction

    // ********
    // Main sequence
    // ********
    initial begin
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rdc(OFS_LEVEL, 32'hA);
        wr(OFS_LEVEL, 32'h4E20);
        rdc(OFS_LEVEL, 32'h2710);
        rdc(5'h1E, 32'h0);
        rdc(OFS_PPR, 32'h800);
        $display("Test registers done");
        wr(OFS_LEVEL, 32'h64);
        spd_ref <= 16'h01F4;
        req     <= 1'b1;
        wr(OFS_CTRL, 32'h0);
        cl(1'b0);
        wr(OFS_CTRL, 32'h100);
        cl(1'b0);
        spd_ref <= 16'h0032;
        cl(1'b1);
        spd_ref <= 16'h01F4;
        cl(1'b1);
        chk({16'h0, cmd}, 32'h0);
        rdc(OFS_HOLD, 32'h3E8);
        enc_pos <= enc_pos + 32'h1;
        cl(1'b1);
        chk({16'h0, cmd}, 32'hFFF0);
        rdc(OFS_SPDCMD, 32'hFFFFFFF0);
        req <= 1'b0;
        cl(1'b0);
        chk({16'h0, cmd}, 32'h000001F4);
        spd_ref <= 16'h0096;
        req     <= 1'b1;
        cl(1'b0);
        wr(OFS_LEVEL, 32'hC8);
        cl(1'b1);
        req <= 1'b0;
        wr(OFS_MAXSPD, 32'h78);
        req <= 1'b1;
        cl(1'b0);
        spd_ref <= 16'h006E;
        cl(1'b1);
        req <= 1'b0;
        wr(OFS_MAXSPD, 32'h1770);
        spd_ref <= 16'h0032;
        wr(OFS_CTRL, 32'h7100);
        cl(1'b1);
        wr(OFS_CTRL, 32'h7101);
        cl(1'b0);
        prop <= 1'b1;
        wr(OFS_CTRL, 32'h800A);
        cl(1'b1);
        prop <= 1'b0;
        cl(1'b0);
        req <= 1'b1;
        for (int c = 0; c < 16; c++) begin
            for (int s = 0; s < 2; s++) begin
                sw <= s[0];
                wr(OFS_CTRL, 32'h100 | 32'(c));
                cl(exp_cl(c, s));
            end
        end
        req <= 1'b0;
        wr(OFS_CTRL, 32'h0);
        cl(1'b0);
        $display("Test clamp done");
        for (int i = 0; i < 2; i++) begin
            wr(OFS_PPR, 32'(16 << i));
            snap;
            steps(128, 1'b1);
            chk(a_rises - a0, 16 << i);
            chk(org_rises - o0, 1);
            chk(pos - p0, 64 << i);
            snap;
            steps(128, 1'b0);
            chk(pos - p0, -(64 << i));
        end
        wr(OFS_CTRL, 32'h10);
        snap;
        steps(128, 1'b1);
        chk(pos - p0, 128);
        chk(a_rises - a0, 32);
        $display("Test pulses done");
        close_out;
    end
endmodule

bind zcpo_top zcpo_top_chk i_chk (
    .core_clk(core_clk), .reset_n(reset_n), .encoder_step(encoder_step),
    .encoder_dir_up(encoder_dir_up), .encoder_position(encoder_position),
    .speed_reference(speed_reference), .speed_command(speed_command),
    .clamp_active(clamp_active), .feedback_phase_a(feedback_phase_a),
    .feedback_phase_b(feedback_phase_b), .feedback_origin_pulse(feedback_origin_pulse)
);
`default_nettype wire
